// >>> sim/host_model.sv
module host_model (
    input wire logic mclk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output logic [6:0] addr_o,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic [15:0] wdata_o,
    output logic [1:0] key_o = 2'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic write(input logic [6:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge mclk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask : write
    task automatic read(input logic [6:0] a, output logic [15:0] d);
        @(negedge mclk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge mclk_i);
        rd_o = 1'b0;
        d = rvalid_i ? rdata_i : 16'hDEAD;
    endtask : read
endmodule : host_model

// >>> sim/swk_cfg_properties.sv
module selective_wake_cfg_properties (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic soft_reset_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rvalid_o,
    input wire logic [1:0] trim_enable_i,
    input wire logic wake_receiver_choice_o,
    input wire logic [6:0] oscillator_coarse_trim_o,
    input wire logic recovery_enable_o,
    input wire logic [1:0] recovery_clock_select_o,
    input wire logic recovery_clk_en_o,
    input wire logic [5:0] recovery_filter_constant_o,
    input wire logic [7:0] upper_bit_time_limit_o,
    input wire logic [7:0] lower_bit_time_limit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    logic tw;
    logic cw;
    assign tw = reg_wr_i && reg_addr_i == 7'h3C && !soft_reset_i;
    assign cw = reg_wr_i && reg_addr_i == 7'h3E && !soft_reset_i;
    read_pulse_a: assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read answer timing");
    trim_take_a: assert property (tw && trim_enable_i == 2'h3 |=>
        oscillator_coarse_trim_o == $past(reg_wdata_i[6:0])) else $error("trim not taken");
    trim_keep_a: assert property (tw && trim_enable_i != 2'h3 |=>
        $stable(oscillator_coarse_trim_o)) else $error("locked trim changed");
    rx_follow_a: assert property (tw && trim_enable_i == 2'h3 |=> ##1
        wake_receiver_choice_o == $past(reg_wdata_i[14], 2)) else $error("receiver choice");
    ctrl_follow_a: assert property (cw |=> ##1 recovery_enable_o == $past(reg_wdata_i[0], 2)
        && recovery_clock_select_o == $past(reg_wdata_i[6:5], 2)) else $error("ctrl outputs");
    filt_fixed_a: assert property (cw && reg_wdata_i[3:2] != 2'h3 |=> ##1
        recovery_filter_constant_o == 6'h08 << $past(reg_wdata_i[3:2], 2)) else $error("filter");
    soft_vals_a: assert property (soft_reset_i |=> !recovery_enable_o &&
        recovery_filter_constant_o == 6'h10 && upper_bit_time_limit_o == 8'h9D &&
        lower_bit_time_limit_o == 8'h8F) else $error("soft reset values");
    div_eight_a: assert property (recovery_enable_o && recovery_clock_select_o == 2'h3 &&
        recovery_clk_en_o |=> !recovery_clk_en_o [*7] ##1 recovery_clk_en_o) else $error("div 8");
    cover property (reg_rvalid_o && $past(reg_addr_i) == 7'h3D);
    cover property (recovery_filter_constant_o == 6'h20);
    cover property (recovery_clk_en_o && recovery_clock_select_o == 2'h3);
endmodule : selective_wake_cfg_properties

bind selective_wake_cdr_config selective_wake_cfg_properties u_props (.mclk_i, .resetn_i,
    .soft_reset_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rvalid_o, .trim_enable_i,
    .wake_receiver_choice_o, .oscillator_coarse_trim_o, .recovery_enable_o,
    .recovery_clock_select_o, .recovery_clk_en_o, .recovery_filter_constant_o,
    .upper_bit_time_limit_o, .lower_bit_time_limit_o);

// >>> sim/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0, resetn_i = 1'b0, soft_reset_i = 1'b0, cal_load_i = 1'b0;
    logic edge_valid_i = 1'b0, reg_wr_i, reg_rd_i, reg_rvalid_o, wake_receiver_choice_o;
    logic recovery_enable_o, recovery_clk_en_o;
    logic [1:0] trim_enable_i, recovery_clock_select_o;
    logic [3:0] edge_distance_i = 4'h0;
    logic [4:0] temp_coef_trim_o;
    logic [5:0] recovery_filter_constant_o;
    logic [6:0] reg_addr_i, oscillator_coarse_trim_o;
    logic [7:0] cal_high_i = 8'h00, cal_low_i = 8'h00, bit_time_setting_i = 8'h96;
    logic [7:0] upper_bit_time_limit_o, lower_bit_time_limit_o;
    logic [15:0] reg_wdata_i, reg_rdata_o, v;
    int miscompares = 0, total_checks = 0, cycles = 0;

    initial forever #12.5 mclk_i = ~mclk_i;
    selective_wake_cdr_config DUT (.mclk_i, .resetn_i, .soft_reset_i, .reg_addr_i, .reg_wr_i,
        .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .trim_enable_i, .cal_load_i,
        .cal_high_i, .cal_low_i, .bit_time_setting_i, .edge_distance_i, .edge_valid_i,
        .wake_receiver_choice_o, .oscillator_coarse_trim_o, .temp_coef_trim_o,
        .recovery_enable_o, .recovery_clock_select_o, .recovery_clk_en_o,
        .recovery_filter_constant_o, .upper_bit_time_limit_o, .lower_bit_time_limit_o);
    host_model h (.mclk_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i),
        .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i), .key_o(trim_enable_i));

    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : check
    task automatic rchk(input string n, input logic [6:0] a, input logic [15:0] e);
        h.read(a, v);
        check(n, v, e);
    endtask : rchk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic t_trim;
        rchk("lim", 7'h3F, 16'h9D8F);
        h.write(7'h3C, 16'hFFFF);
        rchk("locked", 7'h3C, 16'h0000);
        h.key_o = 2'h3;
        h.write(7'h3C, 16'hFFFF);
        rchk("open", 7'h3C, 16'h4FFF);
        check("rx", 16'(wake_receiver_choice_o), 16'h0001);
        check("osc", 16'(oscillator_coarse_trim_o), 16'h007F);
        check("coef", 16'(temp_coef_trim_o), 16'h001F);
        h.key_o = 2'h2;
        h.write(7'h3C, 16'h0000);
        rchk("kept", 7'h3C, 16'h4FFF);
    endtask : t_trim
    task automatic t_cal;
        @(negedge mclk_i);
        {cal_high_i, cal_low_i, cal_load_i} = {16'hA53C, 1'b1};
        @(negedge mclk_i);
        cal_load_i = 1'b0;
        h.write(7'h3D, 16'h0000);
        rchk("cal", 7'h3D, 16'hA53C);
        rchk("gap", 7'h10, 16'h0000);
        h.write(7'h3E, 16'h0001);
        @(negedge mclk_i);
        soft_reset_i = 1'b1;
        @(negedge mclk_i);
        soft_reset_i = 1'b0;
        rchk("cal0", 7'h3D, 16'h0000);
        rchk("ctrl0", 7'h3E, 16'h0004);
        rchk("trim0", 7'h3C, 16'h0000);
        check("rx0", 16'(wake_receiver_choice_o), 16'h0000);
        check("en0", 16'(recovery_enable_o), 16'h0000);
    endtask : t_cal
    task automatic t_limit;
        logic [15:0] pr [3] = '{16'hFF00, 16'h4E47, 16'h9D8F};
        logic [7:0] nm [3] = '{8'h96, 8'h4B, 8'h96};
        int u;
        int l;
        for (int k = 0; k < 3; k++) begin
            bit_time_setting_i = nm[k];
            u = nm[k] * 105 / 100;
            l = nm[k] - nm[k] * 5 / 100;
            if (pr[k][15:8] < u) begin
                u = pr[k][15:8];
            end
            if (pr[k][7:0] > l) begin
                l = pr[k][7:0];
            end
            h.write(7'h3F, pr[k]);
            rchk("limrd", 7'h3F, pr[k]);
            check("up", 16'(upper_bit_time_limit_o), 16'(u));
            check("lo", 16'(lower_bit_time_limit_o), 16'(l));
        end
    endtask : t_limit
    task automatic t_filter;
        logic [5:0] ex [7] = '{6'h20, 6'h20, 6'h10, 6'h10, 6'h10, 6'h08, 6'h08};
        logic [3:0] ds [7] = '{4'h2, 4'h3, 4'h4, 4'h8, 4'hF, 4'h9, 4'hA};
        int n = 0;
        for (int k = 0; k < 3; k++) begin
            h.write(7'h3E, 16'((k << 2) | 1));
            @(negedge mclk_i);
            check("filt", 16'(recovery_filter_constant_o), 16'(8 << k));
            check("clken", 16'(recovery_clk_en_o), 16'h0001);
        end
        h.write(7'h3E, 16'hFFFF);
        rchk("ctrl", 7'h3E, 16'h006D);
        check("en", 16'(recovery_enable_o), 16'h0001);
        check("sel", 16'(recovery_clock_select_o), 16'h0003);
        for (int k = 0; k < 7; k++) begin
            {edge_distance_i, edge_valid_i} = {ds[k], 1'b1};
            @(negedge mclk_i);
            edge_valid_i = 1'b0;
            repeat (2) @(negedge mclk_i);
            check("adapt", 16'(recovery_filter_constant_o), 16'(ex[k]));
        end
        repeat (32) begin
            @(negedge mclk_i);
            n = n + (recovery_clk_en_o === 1'b1);
        end
        check("div8", 16'(n), 16'h0004);
    endtask : t_filter

    initial begin
        repeat (6) @(negedge mclk_i);
        resetn_i = 1'b1;
        t_trim();
        t_cal();
        t_limit();
        t_filter();
        finish_test();
    end
endmodule : testbench

// >>> src/filter_select.sv
`include "swk_cfg.svh"

module filter_select
    import selective_wake_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic soft_reset_i,
    input wire logic [1:0] mode_i,
    input wire logic [3:0] edge_distance_i,
    input wire logic edge_valid_i,
    output logic [5:0] constant_o
);
    filter_state_s st_r;
    filter_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        unique case (mode_i)
            `FILT_8: st_nxt.constant = `TC_8;
            `FILT_16: st_nxt.constant = `TC_16;
            `FILT_32: st_nxt.constant = `TC_32;
            `FILT_ADAPT: begin
                // Out-of-range spacing keeps the last constant
                if (edge_valid_i) begin
                    if (edge_distance_i >= `DIST_32_MIN && edge_distance_i <= `DIST_32_MAX) begin
                        st_nxt.constant = `TC_32;
                    end else if (edge_distance_i >= `DIST_16_MIN
                                 && edge_distance_i <= `DIST_16_MAX) begin
                        st_nxt.constant = `TC_16;
                    end else if (edge_distance_i >= `DIST_8_MIN
                                 && edge_distance_i <= `DIST_8_MAX) begin
                        st_nxt.constant = `TC_8;
                    end
                end
            end
        endcase
        if (soft_reset_i) begin
            st_nxt.constant = `TC_16;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '{constant: `TC_16};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign constant_o = st_r.constant;
endmodule : filter_select

// >>> src/selective_wake_cdr_config.sv
// Overview of operation
// - Receiver select 0 picks the low-power wake receiver, 1 the standard receiver.
// - Receiver select, temperature trim and oscillator trim are writable only with trim key 11.
// - All reserved bits of these registers read as zero.
// - Receiver select resets to 0, the low-power receiver.
// - Calibration register is read-only, high byte over low byte, cleared by reset.
// - Recovery control resets to 0x0004: disabled, constant 16, clock select 00.
// - Filter field 00/01/10/11 gives constant 8/16/32/adaptive.
// - Adaptive mode uses 32, 16 or 8 for edge spacing 2-3, 4-8 or 9-10 bits.
// - Clock select 00/01/10/11 divides the recovery clock by 1/2/4/8.
// - Upper limit is clamped at +5 percent and lower limit at -5 percent of the bit time.
// - Limit register resets to 0x9D8F and is reloaded with it by a soft reset.
`include "swk_cfg.svh"

module selective_wake_cdr_config
    import selective_wake_pkg::*;
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic soft_reset_i,
    input wire logic [`ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`DATA_W-1:0] reg_wdata_i,
    output logic [`DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [1:0] trim_enable_i,
    input wire logic cal_load_i,
    input wire logic [7:0] cal_high_i,
    input wire logic [7:0] cal_low_i,
    input wire logic [7:0] bit_time_setting_i,
    input wire logic [3:0] edge_distance_i,
    input wire logic edge_valid_i,
    output logic wake_receiver_choice_o,
    output logic [6:0] oscillator_coarse_trim_o,
    output logic [4:0] temp_coef_trim_o,
    output logic recovery_enable_o,
    output logic [1:0] recovery_clock_select_o,
    output logic recovery_clk_en_o,
    output logic [5:0] recovery_filter_constant_o,
    output logic [7:0] upper_bit_time_limit_o,
    output logic [7:0] lower_bit_time_limit_o
);
    cfg_state_s st_r;
    cfg_state_s st_nxt;
    // Clamp bounds follow the nominal bit time
    word_t nominal;
    word_t up_cap;
    word_t dn_step;
    word_t dn_cap;
    logic up_over;
    logic dn_under;
    // Divider terminal count for the selected ratio
    logic [`DIV_W-1:0] div_top;
    logic div_wrap;
    logic key_open;

    // Recovery filter constant, fixed or adaptive
    filter_select u_filter (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .soft_reset_i(soft_reset_i),
        .mode_i(st_r.filt),
        .edge_distance_i(edge_distance_i),
        .edge_valid_i(edge_valid_i),
        .constant_o(recovery_filter_constant_o)
    );

    function automatic cfg_state_s reset_state();
        cfg_state_s s;
        s = '0;
        s.rx_sel = 1'(`TRIM_RESET >> `RX_SEL_BIT);
        s.temp_coef = 5'(`TRIM_RESET >> `COEF_LO);
        s.osc_trim = 7'(`TRIM_RESET >> `OSC_LO);
        s.cal_high = byte_t'(`CAL_RESET >> `BYTE_HI_LO);
        s.cal_low = byte_t'(`CAL_RESET);
        s.clk_sel = 2'(`CTRL_RESET >> `CLK_SEL_LO);
        s.filt = 2'(`CTRL_RESET >> `FILT_LO);
        s.enable = 1'(`CTRL_RESET);
        s.lim_high = byte_t'(`LIMIT_RESET >> `BYTE_HI_LO);
        s.lim_low = byte_t'(`LIMIT_RESET);
        s.upper_eff = byte_t'(`LIMIT_RESET >> `BYTE_HI_LO);
        s.lower_eff = byte_t'(`LIMIT_RESET);
        return s;
    endfunction : reset_state

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        nominal = word_t'(bit_time_setting_i);
        up_cap = (nominal * `PCT_UP) / `PCT_DIV;
        dn_step = (nominal * `PCT_DN) / `PCT_DIV;
        dn_cap = nominal - dn_step;
        up_over = word_t'(st_r.lim_high) > up_cap;
        dn_under = word_t'(st_r.lim_low) < dn_cap;
        div_top = `DIV_W'((4'h1 << st_r.clk_sel) - 4'h1);
        div_wrap = st_r.div_cnt >= div_top;
        key_open = trim_enable_i == `TRIM_KEY;

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `TRIM_OFFSET: begin
                    if (key_open) begin
                        st_nxt.rx_sel = reg_wdata_i[`RX_SEL_BIT];
                        st_nxt.temp_coef = reg_wdata_i[`COEF_HI:`COEF_LO];
                        st_nxt.osc_trim = reg_wdata_i[`OSC_HI:`OSC_LO];
                    end else begin
                        // Key closed: fields keep their values
                        st_nxt.rx_sel = st_r.rx_sel;
                    end
                end
                `CAL_OFFSET: begin
                    // Read-only: the write is dropped
                    st_nxt.cal_high = st_r.cal_high;
                end
                `CTRL_OFFSET: begin
                    st_nxt.clk_sel = reg_wdata_i[`CLK_SEL_HI:`CLK_SEL_LO];
                    st_nxt.filt = reg_wdata_i[`FILT_HI:`FILT_LO];
                    st_nxt.enable = reg_wdata_i[`EN_BIT];
                end
                `LIMIT_OFFSET: begin
                    st_nxt.lim_high = reg_wdata_i[`BYTE_HI_HI:`BYTE_HI_LO];
                    st_nxt.lim_low = reg_wdata_i[`BYTE_LO_HI:`BYTE_LO_LO];
                end
                default: begin
                end
            endcase
        end

        // Calibration only changes from the oscillator side or by soft reset
        if (cal_load_i) begin
            st_nxt.cal_high = cal_high_i;
            st_nxt.cal_low = cal_low_i;
        end

        // A read in the cycle of a write returns the old contents
        if (reg_rd_i) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = '0;
            unique case (reg_addr_i)
                `TRIM_OFFSET: begin
                    st_nxt.rdata[`RX_SEL_BIT] = st_r.rx_sel;
                    st_nxt.rdata[`COEF_HI:`COEF_LO] = st_r.temp_coef;
                    st_nxt.rdata[`OSC_HI:`OSC_LO] = st_r.osc_trim;
                end
                `CAL_OFFSET: begin
                    st_nxt.rdata = {st_r.cal_high, st_r.cal_low};
                end
                `CTRL_OFFSET: begin
                    st_nxt.rdata[`CLK_SEL_HI:`CLK_SEL_LO] = st_r.clk_sel;
                    st_nxt.rdata[`FILT_HI:`FILT_LO] = st_r.filt;
                    st_nxt.rdata[`EN_BIT] = st_r.enable;
                end
                `LIMIT_OFFSET: begin
                    // Programmed values, before clamping
                    st_nxt.rdata = {st_r.lim_high, st_r.lim_low};
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end

        // Recovery clock enable: one pulse every 2^select cycles
        if (!st_r.enable) begin
            st_nxt.div_cnt = '0;
            st_nxt.clk_en = 1'b0;
        end else if (div_wrap) begin
            st_nxt.div_cnt = '0;
            st_nxt.clk_en = 1'b1;
        end else begin
            st_nxt.div_cnt = st_r.div_cnt + `DIV_W'(1);
            st_nxt.clk_en = 1'b0;
        end

        // Pin-side copies lag their register bits by one cycle
        st_nxt.rx_out = st_r.rx_sel;
        st_nxt.en_out = st_r.enable;
        st_nxt.clk_sel_out = st_r.clk_sel;

        // Programmed limits beyond five percent do not take effect
        if (up_over) begin
            st_nxt.upper_eff = up_cap[7:0];
        end else begin
            st_nxt.upper_eff = st_r.lim_high;
        end
        if (dn_under) begin
            st_nxt.lower_eff = dn_cap[7:0];
        end else begin
            st_nxt.lower_eff = st_r.lim_low;
        end

        // Soft reset wins over any access decoded above
        if (soft_reset_i) begin
            st_nxt = reset_state();
        end
    end

    // Power-on reset loads the same values as soft reset
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= reset_state();
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign reg_rvalid_o = st_r.rvalid;
    assign wake_receiver_choice_o = st_r.rx_out;
    assign oscillator_coarse_trim_o = st_r.osc_trim;
    assign temp_coef_trim_o = st_r.temp_coef;
    assign recovery_enable_o = st_r.en_out;
    assign recovery_clock_select_o = st_r.clk_sel_out;
    assign recovery_clk_en_o = st_r.clk_en;
    assign upper_bit_time_limit_o = st_r.upper_eff;
    assign lower_bit_time_limit_o = st_r.lower_eff;
endmodule : selective_wake_cdr_config

// >>> src/swk_cfg.svh
`ifndef SELECTIVE_WAKE_CFG_SVH
`define SELECTIVE_WAKE_CFG_SVH

`define ADDR_W 7
`define DATA_W 16
`define TRIM_OFFSET 7'h3C
`define CAL_OFFSET 7'h3D
`define CTRL_OFFSET 7'h3E
`define LIMIT_OFFSET 7'h3F

`define TRIM_KEY 2'h3
`define RX_SEL_BIT 14
`define COEF_HI 11
`define COEF_LO 7
`define OSC_HI 6
`define OSC_LO 0

`define CLK_SEL_HI 6
`define CLK_SEL_LO 5
`define FILT_HI 3
`define FILT_LO 2
`define EN_BIT 0

`define BYTE_HI_HI 15
`define BYTE_HI_LO 8
`define BYTE_LO_HI 7
`define BYTE_LO_LO 0

`define CTRL_RESET 16'h0004
`define LIMIT_RESET 16'h9D8F
`define TRIM_RESET 16'h0000
`define CAL_RESET 16'h0000

`define FILT_8 2'h0
`define FILT_16 2'h1
`define FILT_32 2'h2
`define FILT_ADAPT 2'h3
`define TC_8 6'h08
`define TC_16 6'h10
`define TC_32 6'h20
`define DIST_32_MIN 4'h2
`define DIST_32_MAX 4'h3
`define DIST_16_MIN 4'h4
`define DIST_16_MAX 4'h8
`define DIST_8_MIN 4'h9
`define DIST_8_MAX 4'hA

`define PCT_UP 16'h0069
`define PCT_DIV 16'h0064
`define PCT_DN 16'h0005
`define DIV_W 3

`endif

// >>> src/swk_pkg.sv
`include "swk_cfg.svh"

package selective_wake_pkg;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [7:0] byte_t;

    typedef struct packed {
        logic [5:0] constant;
    } filter_state_s;

    typedef struct packed {
        logic rx_sel;
        logic [4:0] temp_coef;
        logic [6:0] osc_trim;
        byte_t cal_high;
        byte_t cal_low;
        logic [1:0] clk_sel;
        logic [1:0] filt;
        logic enable;
        byte_t lim_high;
        byte_t lim_low;
        word_t rdata;
        logic rvalid;
        logic [`DIV_W-1:0] div_cnt;
        logic clk_en;
        logic rx_out;
        logic en_out;
        logic [1:0] clk_sel_out;
        byte_t upper_eff;
        byte_t lower_eff;
    } cfg_state_s;
endpackage : selective_wake_pkg
